//--- psf_pkg.sv
// constants, register map and state codes for the power sequencing block
// assumes a command port driven by a bus target decoder on the same clock
package psf_pkg;
    // command codes used as register addresses
    localparam logic [7:0] PSF_CMD_CLEAR      = 8'h03;
    localparam logic [7:0] PSF_CMD_PG_ASSERT  = 8'h5e;
    localparam logic [7:0] PSF_CMD_PG_RELEASE = 8'h5f;
    localparam logic [7:0] PSF_CMD_TON_WAIT   = 8'h60;
    localparam logic [7:0] PSF_CMD_RISE_REACT = 8'h63;
    localparam logic [7:0] PSF_CMD_TOFF_WAIT  = 8'h64;
    localparam logic [7:0] PSF_CMD_STATUS     = 8'h78;
    localparam logic [7:0] PSF_CMD_FAULT_UNIT = 8'hd2;
    // values after reset
    localparam logic [15:0] PSF_RST_PG_ASSERT  = 16'h0000;
    localparam logic [15:0] PSF_RST_PG_RELEASE = 16'h0000;
    localparam logic [15:0] PSF_RST_TON_WAIT   = 16'h0000;
    localparam logic [15:0] PSF_RST_TOFF_WAIT  = 16'h0000;
    localparam logic [7:0]  PSF_RST_RISE_REACT = 8'h00;
    localparam logic [7:0]  PSF_RST_FAULT_UNIT = 8'h01;
    // reaction field positions
    localparam int PSF_RESP_HI  = 7;
    localparam int PSF_RESP_LO  = 6;
    localparam int PSF_RETRY_HI = 5;
    localparam int PSF_RETRY_LO = 3;
    localparam int PSF_DLY_HI   = 2;
    localparam int PSF_DLY_LO   = 0;
    localparam logic [1:0] PSF_RESP_IGNORE  = 2'h0;
    localparam logic [1:0] PSF_RESP_RUN     = 2'h1;
    localparam logic [1:0] PSF_RESP_DISABLE = 2'h2;
    localparam logic [1:0] PSF_RESP_RESUME  = 2'h3;
    localparam logic [2:0] PSF_RETRY_NONE    = 3'h0;
    localparam logic [2:0] PSF_RETRY_FOREVER = 3'h7;
    // summary status bit positions
    localparam int PSF_ST_BUSY = 7;
    localparam int PSF_ST_OFF  = 6;
    localparam int PSF_ST_OV   = 5;
    localparam int PSF_ST_OC   = 4;
    localparam int PSF_ST_UV   = 3;
    localparam int PSF_ST_TEMP = 2;
    localparam int PSF_ST_COMM = 1;
    localparam int PSF_ST_NOTA = 0;
    // timing: one millisecond at the 25 MHz system clock
    localparam int  PSF_CLK_HZ     = 25_000_000;
    localparam int  PSF_MS_PER_S   = 1000;
    localparam int  PSF_CYC_PER_MS = PSF_CLK_HZ / PSF_MS_PER_S;
    localparam int  PSF_TON_MAX_MS = 50;
    typedef enum logic [2:0] {
        PSF_OFF, PSF_ON_WAIT, PSF_RAMP, PSF_ON, PSF_OFF_WAIT,
        PSF_RUN_HOLD, PSF_RETRY_WAIT, PSF_LATCHED
    } psf_state_t;
endpackage

//--- psf_seq.sv
// power sequencing, turn-on timeout reaction and summary status
// assumes pins enable/fault are asynchronous; vout code and commands share clk_in
//
// Contract
// - hold power-good assert threshold, unsigned exp -11
// - hold power-good release threshold, same coding
// - wait turn-on delay from enable to rise
// - wait turn-off delay from disable to fall
// - reaction 00: keep operating through the fault
// - reaction 01: run for delay, then retry action
// - reaction 10: disable at once, then retry action
// - reaction 11: disabled while faulted, resume automatically
// - retries 000: stay disabled until cleared
// - delay field counts two to its power units
// - time unit comes from register 0xD2
// - status bit 7 shows busy
// - status bit 6 shows output not powered
// - status bit 5 shows output overvoltage
// - status bit 4 shows output overcurrent
// - status bit 3 shows input undervoltage
// - status bit 2 shows temperature fault or warning
// - status bit 1 shows communication/memory/logic fault
// - status bit 0 shows any other fault
`timescale 1ns/1ps
module psf_seq
    import psf_pkg::*;
#(
    parameter int CYC_PER_MS = PSF_CYC_PER_MS,
    parameter int TON_MAX_MS = PSF_TON_MAX_MS
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        enable_in,
    input  wire logic [15:0] vout_code_in,
    input  wire logic        fault_ov_in,
    input  wire logic        fault_oc_in,
    input  wire logic        fault_uv_in,
    input  wire logic        fault_temp_in,
    input  wire logic        fault_comm_in,
    input  wire logic        fault_other_in,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic [15:0] cmd_wdata_in,
    output logic [15:0]      cmd_rdata_out,
    output logic             cmd_done_out,
    output logic             cmd_unsupported_out,
    output logic             power_on_out,
    output logic             output_good_signal_out
);
    // linear format to whole milliseconds; negatives give zero, overflow saturates
    function automatic logic [23:0] lin_to_ms(input logic [15:0] lin);
        logic signed [4:0]  ex;
        logic        [10:0] mant;
        logic        [39:0] wide;
        ex   = lin[15:11];
        mant = lin[10:0];
        wide = 40'h0;
        if (!mant[10]) begin
            if (ex >= 0)
                wide = {29'h0, mant} << ex;
            else
                wide = {29'h0, mant} >> (-ex);
        end
        if (wide[39:24] != 16'h0)
            lin_to_ms = 24'hff_ffff;
        else
            lin_to_ms = wide[23:0];
    endfunction

    // two-flop synchronisers for the pin inputs
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= {1'b0, fault_other_in, fault_comm_in, fault_temp_in,
                        fault_uv_in, fault_oc_in, fault_ov_in, enable_in};
            sync2_r <= sync1_r;
        end
    end
    logic en_s;
    assign en_s = sync2_r[0];

    // command registers
    logic [15:0] pg_assert_r;
    logic [15:0] pg_assert_nxt;
    logic [15:0] pg_release_r;
    logic [15:0] pg_release_nxt;
    logic [15:0] ton_wait_r;
    logic [15:0] ton_wait_nxt;
    logic [15:0] toff_wait_r;
    logic [15:0] toff_wait_nxt;
    logic [7:0]  react_r;
    logic [7:0]  react_nxt;
    logic [7:0]  unit_r;
    logic [7:0]  unit_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        unsup_r;
    logic        unsup_nxt;
    logic        clear_cmd;
    logic [7:0]  status;

    always_comb begin
        pg_assert_nxt  = pg_assert_r;
        pg_release_nxt = pg_release_r;
        ton_wait_nxt   = ton_wait_r;
        toff_wait_nxt  = toff_wait_r;
        react_nxt      = react_r;
        unit_nxt       = unit_r;
        rdata_nxt      = rdata_r;
        done_nxt       = cmd_valid_in;
        unsup_nxt      = 1'b0;
        clear_cmd      = 1'b0;
        if (cmd_valid_in) begin
            unique case (cmd_code_in)
                PSF_CMD_PG_ASSERT: begin
                    if (cmd_write_in) pg_assert_nxt = cmd_wdata_in;
                    rdata_nxt = pg_assert_r;
                end
                PSF_CMD_PG_RELEASE: begin
                    if (cmd_write_in) pg_release_nxt = cmd_wdata_in;
                    rdata_nxt = pg_release_r;
                end
                PSF_CMD_TON_WAIT: begin
                    if (cmd_write_in) ton_wait_nxt = cmd_wdata_in;
                    rdata_nxt = ton_wait_r;
                end
                PSF_CMD_TOFF_WAIT: begin
                    if (cmd_write_in) toff_wait_nxt = cmd_wdata_in;
                    rdata_nxt = toff_wait_r;
                end
                PSF_CMD_RISE_REACT: begin
                    if (cmd_write_in) react_nxt = cmd_wdata_in[7:0];
                    rdata_nxt = {8'h00, react_r};
                end
                PSF_CMD_FAULT_UNIT: begin
                    if (cmd_write_in) unit_nxt = cmd_wdata_in[7:0];
                    rdata_nxt = {8'h00, unit_r};
                end
                PSF_CMD_STATUS: begin
                    unsup_nxt = cmd_write_in;
                    rdata_nxt = {8'h00, status};
                end
                PSF_CMD_CLEAR: begin
                    clear_cmd = cmd_write_in;
                    unsup_nxt = !cmd_write_in;
                    rdata_nxt = 16'h0000;
                end
                default: begin
                    unsup_nxt = 1'b1;
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pg_assert_r  <= PSF_RST_PG_ASSERT;
            pg_release_r <= PSF_RST_PG_RELEASE;
            ton_wait_r   <= PSF_RST_TON_WAIT;
            toff_wait_r  <= PSF_RST_TOFF_WAIT;
            react_r      <= PSF_RST_RISE_REACT;
            unit_r       <= PSF_RST_FAULT_UNIT;
            rdata_r      <= 16'h0000;
            done_r       <= 1'b0;
            unsup_r      <= 1'b0;
        end else begin
            pg_assert_r  <= pg_assert_nxt;
            pg_release_r <= pg_release_nxt;
            ton_wait_r   <= ton_wait_nxt;
            toff_wait_r  <= toff_wait_nxt;
            react_r      <= react_nxt;
            unit_r       <= unit_nxt;
            rdata_r      <= rdata_nxt;
            done_r       <= done_nxt;
            unsup_r      <= unsup_nxt;
        end
    end
    assign cmd_rdata_out       = rdata_r;
    assign cmd_done_out        = done_r;
    assign cmd_unsupported_out = unsup_r;

    // sequencer
    psf_state_t  state_r;
    psf_state_t  state_nxt;
    logic [23:0] cnt_r;
    logic [23:0] cnt_nxt;
    logic [31:0] prs_r;
    logic [31:0] prs_nxt;
    logic [2:0]  tries_r;
    logic [2:0]  tries_nxt;
    logic        pwr_r;
    logic        pwr_nxt;
    logic        pg_r;
    logic        pg_nxt;
    logic        ms_tick;
    logic        reached;
    logic        ton_timeout;
    logic [1:0]  resp;
    logic [2:0]  retries;
    logic [23:0] units;

    assign ms_tick = (prs_r == 32'(CYC_PER_MS - 1));
    assign reached = (vout_code_in >= pg_assert_r);
    assign resp    = react_r[PSF_RESP_HI:PSF_RESP_LO];
    assign retries = react_r[PSF_RETRY_HI:PSF_RETRY_LO];
    // a unit of zero would make the hold vanish; treat it as one millisecond
    assign units   = (24'h1 << react_r[PSF_DLY_HI:PSF_DLY_LO])
                   * ((unit_r == 8'h00) ? 24'h1 : {16'h0, unit_r});
    assign ton_timeout = (state_r == PSF_RAMP) && en_s && !reached
                       && (cnt_r == 24'h0);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (ms_tick && cnt_r != 24'h0) ? cnt_r - 24'h1 : cnt_r;
        tries_nxt = tries_r;
        unique case (state_r)
            PSF_OFF: begin
                if (en_s) begin
                    state_nxt = PSF_ON_WAIT;
                    cnt_nxt   = lin_to_ms(ton_wait_r);
                    tries_nxt = retries;
                end
            end
            PSF_ON_WAIT: begin
                if (!en_s) begin
                    state_nxt = PSF_OFF;
                end else if (cnt_r == 24'h0) begin
                    state_nxt = PSF_RAMP;
                    cnt_nxt   = 24'(TON_MAX_MS);
                end
            end
            PSF_RAMP, PSF_RUN_HOLD: begin
                if (!en_s) begin
                    state_nxt = PSF_OFF_WAIT;
                    cnt_nxt   = lin_to_ms(toff_wait_r);
                end else if (reached) begin
                    state_nxt = PSF_ON;
                end else if (cnt_r == 24'h0) begin
                    if (state_r == PSF_RAMP && resp == PSF_RESP_IGNORE) begin
                        state_nxt = PSF_ON;
                    end else if (state_r == PSF_RAMP && resp == PSF_RESP_RUN) begin
                        state_nxt = PSF_RUN_HOLD;
                        cnt_nxt   = units;
                    end else if (state_r == PSF_RAMP && resp == PSF_RESP_RESUME) begin
                        state_nxt = PSF_RETRY_WAIT;
                        cnt_nxt   = 24'h0;
                    end else if (tries_r == PSF_RETRY_NONE) begin
                        state_nxt = PSF_LATCHED;
                    end else begin
                        state_nxt = PSF_RETRY_WAIT;
                        cnt_nxt   = units;
                        if (tries_r != PSF_RETRY_FOREVER)
                            tries_nxt = tries_r - 3'h1;
                    end
                end
            end
            PSF_RETRY_WAIT: begin
                if (!en_s) begin
                    state_nxt = PSF_OFF;
                end else if (cnt_r == 24'h0) begin
                    state_nxt = PSF_RAMP;
                    cnt_nxt   = 24'(TON_MAX_MS);
                end
            end
            PSF_ON: begin
                if (!en_s) begin
                    state_nxt = PSF_OFF_WAIT;
                    cnt_nxt   = lin_to_ms(toff_wait_r);
                end
            end
            PSF_OFF_WAIT: begin
                if (en_s)
                    state_nxt = PSF_ON;
                else if (cnt_r == 24'h0)
                    state_nxt = PSF_OFF;
            end
            PSF_LATCHED: begin
                if (!en_s || clear_cmd)
                    state_nxt = PSF_OFF;
            end
        endcase
        // the millisecond grid restarts on every state change so a hold is never short
        prs_nxt = (state_nxt != state_r || ms_tick) ? 32'h0 : prs_r + 32'h1;
        pwr_nxt = (state_nxt == PSF_RAMP) || (state_nxt == PSF_ON)
               || (state_nxt == PSF_OFF_WAIT) || (state_nxt == PSF_RUN_HOLD);
        if (!pwr_r)
            pg_nxt = 1'b0;
        else if (pg_r)
            pg_nxt = (vout_code_in >= pg_release_r);
        else
            pg_nxt = reached;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= PSF_OFF;
            cnt_r   <= 24'h0;
            prs_r   <= 32'h0;
            tries_r <= 3'h0;
            pwr_r   <= 1'b0;
            pg_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            prs_r   <= prs_nxt;
            tries_r <= tries_nxt;
            pwr_r   <= pwr_nxt;
            pg_r    <= pg_nxt;
        end
    end
    assign power_on_out           = pwr_r;
    assign output_good_signal_out = pg_r;

    // sticky fault classes; an event in the clearing cycle survives
    logic [5:0] stick_r;
    logic [5:0] stick_nxt;
    logic [5:0] events;
    assign events = {ton_timeout | sync2_r[6], sync2_r[5:1]};
    always_comb begin
        stick_nxt = (clear_cmd ? 6'h00 : stick_r) | events;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in)
            stick_r <= 6'h00;
        else
            stick_r <= stick_nxt;
    end
    always_comb begin
        status              = 8'h00;
        status[PSF_ST_BUSY] = (state_r == PSF_ON_WAIT) || (state_r == PSF_RAMP)
                           || (state_r == PSF_OFF_WAIT) || (state_r == PSF_RETRY_WAIT)
                           || (state_r == PSF_RUN_HOLD);
        status[PSF_ST_OFF]  = !pwr_r;
        status[PSF_ST_OV]   = stick_r[0];
        status[PSF_ST_OC]   = stick_r[1];
        status[PSF_ST_UV]   = stick_r[2];
        status[PSF_ST_TEMP] = stick_r[3];
        status[PSF_ST_COMM] = stick_r[4];
        status[PSF_ST_NOTA] = stick_r[5];
    end

    property p_pg_up;
        @(posedge clk_in) disable iff (rst_in)
        (pwr_r && !pg_r && vout_code_in >= pg_assert_r) |=> pg_r;
    endproperty
    a_pg_up: assert property (p_pg_up) else $error("power good missed assert level");
    property p_pg_down;
        @(posedge clk_in) disable iff (rst_in)
        (pg_r && vout_code_in < pg_release_r) |=> !pg_r;
    endproperty
    a_pg_down: assert property (p_pg_down) else $error("power good held below release");
    property p_on_wait;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == PSF_OFF && en_s) |=> (state_r == PSF_ON_WAIT && !pwr_r);
    endproperty
    a_on_wait: assert property (p_on_wait) else $error("enable did not start turn-on wait");
    property p_off_wait;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == PSF_ON && !en_s) |=> (state_r == PSF_OFF_WAIT && pwr_r);
    endproperty
    a_off_wait: assert property (p_off_wait) else $error("disable dropped output early");
    property p_ignore;
        @(posedge clk_in) disable iff (rst_in)
        (ton_timeout && resp == PSF_RESP_IGNORE) |=> (state_r == PSF_ON && pwr_r);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored fault interrupted output");
    property p_run;
        @(posedge clk_in) disable iff (rst_in)
        (ton_timeout && resp == PSF_RESP_RUN) |=> (state_r == PSF_RUN_HOLD && pwr_r);
    endproperty
    a_run: assert property (p_run) else $error("run reaction did not keep output on");
    property p_disable;
        @(posedge clk_in) disable iff (rst_in)
        (ton_timeout && resp == PSF_RESP_DISABLE) |=> !pwr_r;
    endproperty
    a_disable: assert property (p_disable) else $error("disable reaction left output on");
    property p_latched;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == PSF_LATCHED && en_s && !clear_cmd) |=> (state_r == PSF_LATCHED && !pwr_r);
    endproperty
    a_latched: assert property (p_latched) else $error("latched fault restarted output");
    property p_sticky;
        @(posedge clk_in) disable iff (rst_in)
        (sync2_r[1] && clear_cmd) |=> status[PSF_ST_OV];
    endproperty
    a_sticky: assert property (p_sticky) else $error("overvoltage lost against clear");
endmodule

//--- psf_host.sv
// bus host model issuing command reads and writes to the sequencer
// assumes one shared clock and the one-cycle done answer of the command port
`timescale 1ns/1ps
module psf_host (
    input  wire logic        clk_in,
    input  wire logic [15:0] cmd_rdata_in,
    input  wire logic        cmd_done_in,
    input  wire logic        cmd_unsupported_in,
    output logic             cmd_valid_out,
    output logic             cmd_write_out,
    output logic [7:0]       cmd_code_out,
    output logic [15:0]      cmd_wdata_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_write_out = 1'b0;
        cmd_code_out  = 8'h00;
        cmd_wdata_out = 16'h0000;
    end

    task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                          output logic [15:0] q, output logic u);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_write_out <= w;
        cmd_code_out  <= c;
        cmd_wdata_out <= d;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        // released lines show the inverse so a stale decode cannot pass
        cmd_write_out <= ~w;
        cmd_code_out  <= ~c;
        cmd_wdata_out <= ~d;
        // done stands only in the cycle after the taking edge, so read it at the next edge
        @(posedge clk_in);
        while (cmd_done_in !== 1'b1 && n < 4) begin
            @(posedge clk_in);
            n++;
        end
        q = (cmd_done_in === 1'b1) ? cmd_rdata_in : 16'hxxxx;
        u = cmd_unsupported_in;
    endtask
endmodule

//--- tb_top.sv
// self-checking bench for the power sequencer with the host model
// assumes shortened timing: 10 cycles per ms, 3 ms allowed rise
`timescale 1ns/1ps
module tb_top;
    import psf_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        enable = 1'b0;
    logic [15:0] vout   = 16'h0000;
    logic [5:0]  flt    = 6'h00;
    logic        valid, write, done, unsup, power_on, good;
    logic [7:0]  code;
    logic [15:0] wdata, rdata;
    int          n_fail = 0;
    int          n_compared = 0;

    always #20 clk_in = ~clk_in;

    psf_seq #(.CYC_PER_MS(10), .TON_MAX_MS(3)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .enable_in(enable), .vout_code_in(vout),
        .fault_ov_in(flt[5]), .fault_oc_in(flt[4]), .fault_uv_in(flt[3]),
        .fault_temp_in(flt[2]), .fault_comm_in(flt[1]), .fault_other_in(flt[0]),
        .cmd_valid_in(valid), .cmd_write_in(write), .cmd_code_in(code),
        .cmd_wdata_in(wdata), .cmd_rdata_out(rdata), .cmd_done_out(done),
        .cmd_unsupported_out(unsup), .power_on_out(power_on),
        .output_good_signal_out(good));

    psf_host u_host (
        .clk_in(clk_in), .cmd_rdata_in(rdata), .cmd_done_in(done),
        .cmd_unsupported_in(unsup), .cmd_valid_out(valid), .cmd_write_out(write),
        .cmd_code_out(code), .cmd_wdata_out(wdata));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] q);
        logic u;
        u_host.access(1'b0, c, 16'h0000, q, u);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] q;
        logic        u;
        u_host.access(1'b1, c, d, q, u);
    endtask

    // counts cycles until the regulator drive reaches lv, judged against a window
    task automatic wait_pw(input logic lv, input int lo, input int hi);
        int n;
        n = 0;
        while (power_on !== lv && n < hi + 5) begin
            @(posedge clk_in);
            n++;
        end
        chk(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    task automatic t_regs();
        logic [15:0] q;
        logic        u;
        logic [7:0]  c [5] = '{8'h5e, 8'h5f, 8'h60, 8'h63, 8'h64};
        foreach (c[i]) begin
            rd(c[i], q);
            chk(q, 16'h0000);
            wr(c[i], 16'hc3a5);
            rd(c[i], q);
            chk(q, (c[i] == 8'h63) ? 16'h00a5 : 16'hc3a5);
        end
        rd(8'hd2, q);
        chk(q, 16'h0001);
        u_host.access(1'b1, 8'h78, 16'hffff, q, u);
        chk({15'h0000, u}, 16'h0001);
        u_host.access(1'b0, 8'h10, 16'h0000, q, u);
        chk({q[14:0], u}, 16'h0001);
        rd(8'h78, q);
        chk(q, 16'h0040);
    endtask

    task automatic go(input logic [7:0] react, input logic [7:0] unit);
        wr(8'h63, {8'h00, react});
        wr(8'hd2, {8'h00, unit});
        @(posedge clk_in);
        vout   <= 16'h0000;
        enable <= 1'b1;
        wait_pw(1'b1, 20, 36);
    endtask

    task automatic off();
        @(posedge clk_in);
        enable <= 1'b0;
        vout   <= 16'h0000;
        wait_pw(1'b0, 10, 24);
        wr(8'h03, 16'h0000);
    endtask

    task automatic t_on_off();
        logic [15:0] q;
        wr(8'h5e, 16'h0800);
        wr(8'h5f, 16'h0400);
        wr(8'h60, 16'h0002);
        wr(8'h64, 16'h0001);
        go(8'h00, 8'h01);
        rd(8'h78, q);
        chk(q, 16'h0080);
        vout <= 16'h0900;
        repeat (4) @(posedge clk_in);
        chk({15'h0000, good}, 16'h0001);
        vout <= 16'h0600;
        repeat (4) @(posedge clk_in);
        chk({15'h0000, good}, 16'h0001);
        vout <= 16'h0300;
        repeat (4) @(posedge clk_in);
        chk({15'h0000, good}, 16'h0000);
        rd(8'h78, q);
        chk(q, 16'h0000);
        off();
        rd(8'h78, q);
        chk(q, 16'h0040);
    endtask

    task automatic t_react();
        logic [15:0] q;
        logic [7:0]  r [3] = '{8'h41, 8'h42, 8'h40};
        logic [7:0]  un [3] = '{8'h01, 8'h02, 8'h03};
        int          e [3] = '{50, 110, 60};
        go(8'h00, 8'h01);
        repeat (60) @(posedge clk_in);
        chk({15'h0000, power_on}, 16'h0001);
        rd(8'h78, q);
        chk(q & 16'h0001, 16'h0001);
        off();
        go(8'h80, 8'h01);
        wait_pw(1'b0, 20, 44);
        repeat (100) @(posedge clk_in);
        chk({15'h0000, power_on}, 16'h0000);
        rd(8'h78, q);
        chk(q, 16'h0041);
        enable <= 1'b0;
        wr(8'h03, 16'h0000);
        go(8'hc0, 8'h01);
        wait_pw(1'b0, 20, 44);
        wait_pw(1'b1, 1, 16);
        vout <= 16'h0900;
        repeat (60) @(posedge clk_in);
        chk({15'h0000, power_on}, 16'h0001);
        off();
        // disable with one retry: off, wait two units, ramp again, then latch
        go(8'h89, 8'h01);
        wait_pw(1'b0, 20, 44);
        wait_pw(1'b1, 15, 30);
        wait_pw(1'b0, 25, 40);
        enable <= 1'b0;
        wr(8'h03, 16'h0000);
        // run-hold length differs per delay code and unit, so a swapped field shows
        foreach (r[i]) begin
            go(r[i], un[i]);
            wait_pw(1'b0, e[i] - 12, e[i] + 12);
            enable <= 1'b0;
            wr(8'h03, 16'h0000);
        end
    endtask

    task automatic t_faults();
        logic [15:0] q;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in);
            flt <= 6'h01 << i;
            @(posedge clk_in);
            flt <= 6'h00;
            repeat (4) @(posedge clk_in);
            rd(8'h78, q);
            chk(q, 16'h0040 | (16'h0001 << i));
            wr(8'h03, 16'h0000);
            rd(8'h78, q);
            chk(q, 16'h0040);
        end
        // a fault still standing while the clear lands must survive it
        @(posedge clk_in);
        flt <= 6'h20;
        repeat (3) @(posedge clk_in);
        wr(8'h03, 16'h0000);
        flt <= 6'h00;
        rd(8'h78, q);
        chk(q, 16'h0060);
        wr(8'h03, 16'h0000);
        rd(8'h78, q);
        chk(q, 16'h0040);
    endtask

    task automatic finish_test();
        $display("errors %0d compared %0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_on_off();
        t_react();
        t_faults();
        finish_test();
    end

    // the whole run needs little over a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        finish_test();
    end
endmodule
